//--- core/tmc_pkg.sv
// package for the 16-bit event-reset timer: register map, field layout,
// reset values and the carrier types shared by the timer core.
// assumes a 32-bit AXI4-Lite register bus, one register per aligned word.
package tmc_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_CNT_LO = 8'h00;
  localparam logic [7:0] OFF_CNT_HI = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN = 8'h14;

  // ****************************************
  // field positions and values after reset
  // ****************************************
  localparam int OVF_BIT = 1;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [7:0] HBUF_RST = 8'h00;
  localparam logic [2:0] PSC_RST = 3'h0;
  localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hb;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // carrier types
  // ****************************************
  // counter_control, bit 7 down to bit 0
  typedef struct packed {
    logic wide_access_enable;
    logic ccp_timer_select_upper;
    logic prescale_select_upper;
    logic prescale_select_lower;
    logic ccp_timer_select_lower;
    logic clock_sync_control;
    logic external_clock_select;
    logic counter_run_enable;
  } tmc_ctrl_t;

  // one capture/compare unit as seen by the timer
  typedef struct packed {
    logic match;
    logic [3:0] compare_mode_field;
  } tmc_ccp_t;

endpackage

//--- core/tmc_timer.sv
// 16-bit up-counter with buffered wide access, prescaler, overflow
// interrupt and reset by a compare unit's special event trigger.
// assumes the compare units and the neighbour timer run on core_clk;
// the auxiliary oscillator arrives as a slow asynchronous pin.
//
// Contract
// - wide access maps high-byte address to buffer
// - low-byte read copies live high into buffer
// - wide low write loads high from buffer
// - wide mode: no direct live high access
// - only low-byte writes clear the prescaler
// - auxiliary oscillator usable as clock source
// - external select plus oscillator: count rising edges
// - count up, wrap ffff to 0000 overflows
// - overflow sets sticky flag until software clears
// - interrupt only when overflow enable set
// - assigned unit, mode 1011, match: counter zero
// - second unit trigger starts converter if enabled
// - event reset in timer/sync modes only
// - software write beats simultaneous event reset
// - event reset never sets overflow flag
// - control register bit layout as specified
`timescale 1ns/1ps
module tmc_timer #(
  parameter int ADDR_W = 8,
  parameter int NUM_CCP = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // clock sources
  input wire logic aux_osc_pin,
  input wire logic aux_oscillator_enable,
  // compare units and converter
  input wire tmc_pkg::tmc_ccp_t [NUM_CCP-1:0] ccp,
  input wire logic adc_enable,
  output logic adc_start,
  // interrupt
  output logic irq
);
  import tmc_pkg::*;

  // refuse sizes the register map or the trigger wiring cannot serve
  if (ADDR_W < 5 || NUM_CCP < 2) begin : g_bad_size
    $error("tmc_timer: ADDR_W must be >= 5 and NUM_CCP >= 2");
  end

  // ****************************************
  // state
  // ****************************************
  tmc_ctrl_t ctrl;
  logic [15:0] count;
  logic [7:0] hbuf;
  logic [2:0] psc;
  logic ovf_flag;
  logic ovf_en;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane0;
  logic [2:0] osc_sync;

  // ****************************************
  // axi4-lite write side
  // ****************************************
  logic do_wr;
  logic wr_hit;
  logic wr_lo;
  logic wr_hi;
  logic wr_any;
  logic wr_ctrl;
  logic wr_clr;
  logic wr_en;

  // awready/wready low means an address or data word is held
  assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_hit = (aw_addr == ADDR_W'(OFF_CNT_LO)) ||
                  (aw_addr == ADDR_W'(OFF_CNT_HI)) ||
                  (aw_addr == ADDR_W'(OFF_CTRL)) ||
                  (aw_addr == ADDR_W'(OFF_IRQ_STAT)) ||
                  (aw_addr == ADDR_W'(OFF_IRQ_CLR)) ||
                  (aw_addr == ADDR_W'(OFF_IRQ_EN));
  assign wr_lo = do_wr && w_lane0 && aw_addr == ADDR_W'(OFF_CNT_LO);
  assign wr_hi = do_wr && w_lane0 && aw_addr == ADDR_W'(OFF_CNT_HI);
  assign wr_ctrl = do_wr && w_lane0 && aw_addr == ADDR_W'(OFF_CTRL);
  assign wr_clr = do_wr && w_lane0 && aw_addr == ADDR_W'(OFF_IRQ_CLR);
  assign wr_en = do_wr && w_lane0 && aw_addr == ADDR_W'(OFF_IRQ_EN);
  // a high-byte write in wide mode only touches the buffer
  assign wr_any = wr_lo || (wr_hi && !ctrl.wide_access_enable);

  // address and data are taken in either order, then one write is done
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_addr <= '0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end else if (do_wr) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end else if (do_wr) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // write response, slave error for an unmapped address
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // axi4-lite read side
  // ****************************************
  logic rd_take;
  logic rd_lo;
  logic [7:0] rd_byte;
  logic rd_hit;

  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_lo = rd_take && s_axi_araddr == ADDR_W'(OFF_CNT_LO);

  // read mux; the high-byte address shows the buffer in wide mode
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_W'(OFF_CNT_LO): rd_byte = count[7:0];
      ADDR_W'(OFF_CNT_HI): rd_byte = ctrl.wide_access_enable ? hbuf :
                                     count[15:8];
      ADDR_W'(OFF_CTRL): rd_byte = ctrl;
      ADDR_W'(OFF_IRQ_STAT): rd_byte[OVF_BIT] = ovf_flag;
      ADDR_W'(OFF_IRQ_CLR): rd_byte = 8'h00;
      ADDR_W'(OFF_IRQ_EN): rd_byte[OVF_BIT] = ovf_en;
      default: rd_hit = 1'b0;
    endcase
  end

  // one read at a time, answered in the cycle after the address is taken
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // control and high-byte buffer
  // ****************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= w_data;
    end
  end

  // a low-byte read freezes the matching high byte for a later read
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hbuf <= HBUF_RST;
    end else if (rd_lo && ctrl.wide_access_enable) begin
      hbuf <= count[15:8];
    end else if (wr_hi && ctrl.wide_access_enable) begin
      hbuf <= w_data;
    end
  end

  // ****************************************
  // clock source and prescaler
  // ****************************************
  logic aux_rise;
  logic src_pulse;
  logic [2:0] psc_limit;
  logic tick;

  // pin is asynchronous: two flops, then a third for the edge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      osc_sync <= 3'h0;
    end else begin
      osc_sync <= {osc_sync[1:0], aux_osc_pin};
    end
  end

  assign aux_rise = osc_sync[1] && !osc_sync[2];
  // the oscillator only counts while the neighbour timer enables it
  assign src_pulse = ctrl.external_clock_select ?
                     (aux_oscillator_enable && aux_rise) :
                     1'b1;
  // ratio 1, 2, 4 or 8; >= lets a count above a smaller new limit wrap
  assign psc_limit = 3'((4'h1 << {ctrl.prescale_select_upper,
                                  ctrl.prescale_select_lower}) - 4'h1);
  assign tick = ctrl.counter_run_enable && src_pulse &&
                psc >= psc_limit;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      psc <= PSC_RST;
    end else if (wr_lo) begin
      psc <= PSC_RST;
    end else if (ctrl.counter_run_enable && src_pulse) begin
      psc <= (psc >= psc_limit) ? PSC_RST : psc + 3'h1;
    end
  end

  // ****************************************
  // special event trigger
  // ****************************************
  logic [NUM_CCP-1:0] unit_hit;
  logic trig_reset;
  logic async_mode;

  // select 00: no unit, 01: units from the second up, 1x: all units
  for (genvar k = 0; k < NUM_CCP; k++) begin : g_unit
    logic assigned;
    assign assigned = ctrl.ccp_timer_select_upper ||
                      (ctrl.ccp_timer_select_lower && k >= 1);
    assign unit_hit[k] = assigned && ccp[k].match &&
                         ccp[k].compare_mode_field ==
                         MODE_SPECIAL_EVENT;
  end

  // the reset is simply dropped in asynchronous counter mode
  assign async_mode = ctrl.external_clock_select &&
                      ctrl.clock_sync_control;
  assign trig_reset = (|unit_hit) && !async_mode;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= unit_hit[1] && adc_enable;
    end
  end

  // ****************************************
  // counter
  // ****************************************
  logic ovf;

  assign ovf = tick && count == 16'hffff && !wr_any &&
               !trig_reset;

  // writes first, then the trigger, then counting
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count <= CNT_RST;
    end else if (wr_lo) begin
      count <= {ctrl.wide_access_enable ? hbuf : count[15:8],
                w_data};
    end else if (wr_hi && !ctrl.wide_access_enable) begin
      count[15:8] <= w_data;
    end else if (trig_reset) begin
      count <= CNT_RST;
    end else if (tick) begin
      count <= count + 16'h0001;
    end
  end

  // ****************************************
  // interrupt
  // ****************************************
  // a new overflow beats a clear in the same cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ovf_flag <= 1'b0;
    end else if (ovf) begin
      ovf_flag <= 1'b1;
    end else if (wr_clr && w_data[OVF_BIT]) begin
      ovf_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ovf_en <= 1'b0;
    end else if (wr_en) begin
      ovf_en <= w_data[OVF_BIT];
    end
  end

  // registered so the pin is glitch free; lags the flag by one cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= ovf_flag && ovf_en;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  AST_OVF_SETS_FLAG: assert property (
    ovf |=> ovf_flag ##1 (ovf_flag || $past(wr_clr)))
    else $error("overflow did not set the flag");
  AST_FLAG_STICKY: assert property (
    ovf_flag && !wr_clr |=> ovf_flag)
    else $error("overflow flag dropped without a clear");
  AST_IRQ_GATED: assert property (
    (!ovf_en || !ovf_flag) |=> !irq)
    else $error("interrupt raised while not enabled");
  AST_IRQ_RAISED: assert property (
    ovf_flag && ovf_en |=> irq)
    else $error("enabled overflow gave no interrupt");
  AST_TRIG_ZERO: assert property (
    trig_reset && !wr_lo && !wr_hi |=> count == 16'h0000)
    else $error("event trigger did not clear the counter");
  AST_TRIG_NO_FLAG: assert property (
    trig_reset && !ovf_flag |=> !ovf_flag)
    else $error("event trigger set the overflow flag");
  AST_WRITE_WINS: assert property (
    wr_lo && trig_reset |=> count[7:0] == $past(w_data))
    else $error("event reset beat a low-byte write");
  AST_WIDE_WRITE: assert property (
    wr_lo && ctrl.wide_access_enable |=> count[15:8] == $past(hbuf))
    else $error("wide write did not load the high byte");
  AST_LO_READ_COPY: assert property (
    rd_lo && ctrl.wide_access_enable |=> hbuf == $past(count[15:8]))
    else $error("low-byte read did not fill the buffer");
  AST_HI_READ_BUF: assert property (
    rd_take && s_axi_araddr == ADDR_W'(OFF_CNT_HI) &&
    ctrl.wide_access_enable |=> s_axi_rdata[7:0] == $past(hbuf))
    else $error("high-byte read bypassed the buffer");
  AST_PSC_CLEAR: assert property (
    wr_lo |=> psc == 3'h0)
    else $error("low-byte write did not clear the prescaler");
  AST_FREEZE: assert property (
    !ctrl.counter_run_enable && !wr_any && !trig_reset |=>
    count == $past(count))
    else $error("counter moved while stopped");
  AST_EXT_EDGE: assert property (
    ctrl.external_clock_select && aux_oscillator_enable && aux_rise &&
    ctrl.counter_run_enable && psc_limit == 3'h0 && !wr_any &&
    !trig_reset |=> count == $past(count) + 16'h0001)
    else $error("oscillator edge did not advance the counter");

endmodule

//--- tb/tmc_timer_tb.sv
// self-checking bench for the event-reset timer core.
// assumes the core's register map and reset values from tmc_pkg.
`timescale 1ns/1ps
module tmc_timer_tb;
  import tmc_pkg::*;
  // ********************
  // stimulus and wiring
  // ********************
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid;
  logic bready = 1'b0, arvalid = 1'b0, arready, rvalid, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp, rsp;
  logic aux_pin = 1'b0, aux_en = 1'b0, adc_en = 1'b0;
  logic adc_start, irq;
  tmc_ccp_t [1:0] ccp = {5'h0b, 5'h0b};
  logic [31:0] rv;
  logic [7:0] v;
  int n_fail = 0, n_compared = 0, i, e;

  always #5 core_clk = ~core_clk;

  tmc_timer u_dut (.core_clk(core_clk), .nrst(nrst),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .aux_osc_pin(aux_pin),
    .aux_oscillator_enable(aux_en), .ccp(ccp), .adc_enable(adc_en),
    .adc_start(adc_start), .irq(irq));

  // ********************
  // shared tasks
  // ********************
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, x, g);
    end
  endtask

  // bounded waits end here so a dead handshake never hangs the run
  task automatic late(input int n);
    if (n > 99) chk("handshake", 32'h1, 32'h0);
  endtask

  // ticks that a window of n source pulses yields at ratio 2**code,
  // the prescaler starting from zero
  function automatic int exp_ticks(input int n, input int code);
    return n >> code;
  endfunction

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (((awvalid && !awready) || (wvalid && !wready)) && n < 100);
    do begin
      @(posedge core_clk);
      n++;
    end while (!bvalid && n < 100);
    rsp = bresp;
    bready <= 1'b0;
    late(n);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (!arready && n < 100);
    arvalid <= 1'b0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!rvalid && n < 100);
    rv = rdata;
    rsp = rresp;
    rready <= 1'b0;
    late(n);
  endtask

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [7:0] x);
    rd(a);
    chk(nm, {24'h0, x}, rv);
    chk("rresp", 32'(RESP_OKAY), 32'(rsp));
  endtask

  // one-cycle match pulse, taken by the core at the edge of return
  task automatic trig(input int k);
    @(posedge core_clk);
    ccp[k].match <= 1'b1;
    @(posedge core_clk);
    ccp[k].match <= 1'b0;
  endtask

  task automatic aux(input int n);
    repeat (n) begin
      @(posedge core_clk);
      aux_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      aux_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask

  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    n_fail++;
    finish_test();
  end

  // ********************
  // main sequence
  // ********************
  initial begin
    void'($urandom(32'h75b67840));
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rc("ctrl", OFF_CTRL, CTRL_RST);
    rc("cnt_lo", OFF_CNT_LO, CNT_RST[7:0]);
    rc("stat", OFF_IRQ_STAT, 8'h00);
    rd(8'h1c);
    chk("rresp", 32'(RESP_SLVERR), 32'(rsp));
    wr(8'h1c, 8'h01);
    chk("bresp", 32'(RESP_SLVERR), 32'(rsp));
    $display("test reset done");
    // random round trips with run and wide access off: count frozen
    for (i = 0; i < 6; i++) begin
      v = 8'($urandom) & 8'h7e;
      wr(OFF_CTRL, v);
      rc("ctrl", OFF_CTRL, v);
      v = 8'($urandom);
      wr(OFF_CNT_HI, v);
      wr(OFF_CNT_LO, ~v);
      repeat (10) @(posedge core_clk);
      rc("cnt_hi", OFF_CNT_HI, v);
      rc("cnt_lo", OFF_CNT_LO, ~v);
    end
    $display("test random done");
    // wide access: high byte only through the buffer
    wr(OFF_CTRL, 8'h80);
    wr(OFF_CNT_HI, 8'h12);
    wr(OFF_CNT_LO, 8'h34);
    rc("cnt_lo", OFF_CNT_LO, 8'h34);
    rc("buf", OFF_CNT_HI, 8'h12);
    wr(OFF_CNT_HI, 8'h56);
    rc("buf", OFF_CNT_HI, 8'h56);
    rc("cnt_lo", OFF_CNT_LO, 8'h34);
    rc("buf", OFF_CNT_HI, 8'h12);
    wr(OFF_CTRL, 8'h00);
    rc("cnt_hi", OFF_CNT_HI, 8'h12);
    $display("test wide done");
    // overflow flag and interrupt
    wr(OFF_CNT_HI, 8'hff);
    wr(OFF_CNT_LO, 8'hff);
    wr(OFF_CTRL, 8'h01);
    wr(OFF_CTRL, 8'h00);
    rc("stat", OFF_IRQ_STAT, 8'h02);
    rc("cnt_hi", OFF_CNT_HI, 8'h00);
    chk("irq", 32'h0, 32'(irq));
    wr(OFF_IRQ_EN, 8'h02);
    repeat (2) @(posedge core_clk);
    chk("irq", 32'h1, 32'(irq));
    wr(OFF_IRQ_CLR, 8'h02);
    repeat (2) @(posedge core_clk);
    rc("stat", OFF_IRQ_STAT, 8'h00);
    chk("irq", 32'h0, 32'(irq));
    $display("test overflow done");
    // prescale codes over a fixed run window of 67 source pulses
    for (i = 0; i < 4; i++) begin
      wr(OFF_CNT_HI, 8'h00);
      wr(OFF_CNT_LO, 8'h00);
      wr(OFF_CTRL, 8'(i << 4) | 8'h01);
      repeat (64) @(posedge core_clk);
      wr(OFF_CTRL, 8'h00);
      rd(OFF_CNT_LO);
      e = exp_ticks(67, i);
      chk("prescale", 32'(e), rv);
    end
    $display("test prescale done");
    // event trigger: mode code, selection, priority, async mode
    wr(OFF_CNT_LO, 8'h55);
    trig(0);
    rc("cnt_lo", OFF_CNT_LO, 8'h55);
    wr(OFF_CTRL, 8'h08);
    trig(0);
    rc("cnt_lo", OFF_CNT_LO, 8'h55);
    trig(1);
    rc("cnt_lo", OFF_CNT_LO, 8'h00);
    wr(OFF_CTRL, 8'h48);
    ccp[0].compare_mode_field <= 4'ha;
    wr(OFF_CNT_LO, 8'h55);
    trig(0);
    rc("cnt_lo", OFF_CNT_LO, 8'h55);
    ccp[0].compare_mode_field <= MODE_SPECIAL_EVENT;
    wr(OFF_CNT_HI, 8'hff);
    wr(OFF_CNT_LO, 8'hff);
    trig(0);
    rc("cnt_lo", OFF_CNT_LO, 8'h00);
    rc("cnt_hi", OFF_CNT_HI, 8'h00);
    rc("stat", OFF_IRQ_STAT, 8'h00);
    fork
      wr(OFF_CNT_LO, 8'h77);
      trig(0);
    join
    rc("cnt_lo", OFF_CNT_LO, 8'h77);
    wr(OFF_CTRL, 8'h4e);
    trig(0);
    rc("cnt_lo", OFF_CNT_LO, 8'h77);
    wr(OFF_CTRL, 8'h4a);
    trig(0);
    rc("cnt_lo", OFF_CNT_LO, 8'h00);
    adc_en <= 1'b1;
    trig(1);
    @(posedge core_clk);
    chk("adc_start", 32'h1, 32'(adc_start));
    @(posedge core_clk);
    chk("adc_start", 32'h0, 32'(adc_start));
    adc_en <= 1'b0;
    trig(1);
    @(posedge core_clk);
    chk("adc_start", 32'h0, 32'(adc_start));
    $display("test trigger done");
    // auxiliary oscillator as clock source, gated by its enable
    wr(OFF_CNT_LO, 8'h00);
    wr(OFF_CTRL, 8'h03);
    aux_en <= 1'b1;
    aux(5);
    aux_en <= 1'b0;
    aux(5);
    wr(OFF_CTRL, 8'h00);
    rc("cnt_lo", OFF_CNT_LO, 8'h05);
    $display("test aux clock done");
    // reset in mid-run, counter running in wide mode
    wr(OFF_CTRL, 8'h81);
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rc("ctrl", OFF_CTRL, CTRL_RST);
    rc("cnt_lo", OFF_CNT_LO, CNT_RST[7:0]);
    $display("test mid reset done");
    finish_test();
  end
endmodule
